/* emm_regs.svh */
`ifndef EMM_REGS_SVH
`define EMM_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EMM_OFF_CTRL   8'h00
`define EMM_OFF_MAP    8'h04
`define EMM_OFF_ROMSZ  8'h08
`define EMM_OFF_STAT   8'h0C
`define EMM_OFF_HADDR  8'h10
`define EMM_OFF_HRES   8'h14

// ----------------------------------------
// Control fields
// ----------------------------------------
`define EMM_CTRL_CLK_USER 0
`define EMM_CTRL_BMM      1
`define EMM_CTRL_DEVRST   2
`define EMM_CTRL_SYSRST   3
`define EMM_CTRL_BRKCLR   4

// ----------------------------------------
// Map layout and reset values
// ----------------------------------------
`define EMM_BLOCKS      8
`define EMM_ATTR_W      3
`define EMM_MAP_RST     24'hB6DB6D
`define EMM_ONCHIP_BASE 16'hFA00

// ----------------------------------------
// Timing
// ----------------------------------------
`define EMM_INT_OSC_MHZ 16
`define EMM_CLK_MHZ     125
`define EMM_CPU_RST_NS  1000
`define EMM_CPU_RST_CYC ((`EMM_CPU_RST_NS * `EMM_CLK_MHZ + 999) / 1000)

`endif

/* emm_pkg.sv */
package emm_pkg;
  typedef enum logic [2:0] {
    ATTR_IROM,
    ATTR_TURBO,
    ATTR_ALT,
    ATTR_ALT_WP,
    ATTR_USER,
    ATTR_NONE
  } emm_attr_e;

  typedef enum logic [1:0] {
    BRK_NONE,
    BRK_WP,
    BRK_TURBO,
    BRK_NMAP
  } emm_brk_e;

  typedef logic [23:0] emm_map_t;
endpackage

/* emm_dec_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface emm_dec_if;
  logic              [15:0] addr;
  logic                     valid;
  logic                     wr;
  logic                     burst;
  emm_pkg::emm_map_t        map;
  logic                     to_emu;
  logic                     to_tgt;
  emm_pkg::emm_brk_e        cause;

  modport req (output addr, output valid, output wr, output burst, output map,
               input to_emu, input to_tgt, input cause);
  modport dec (input addr, input valid, input wr, input burst, input map,
               output to_emu, output to_tgt, output cause);
endinterface
`default_nettype wire

/* emm_blk_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "emm_regs.svh"
module emm_blk_decode (
  emm_dec_if.dec d
);
  emm_pkg::emm_attr_e attr;
  logic               onchip;

  always_comb
  begin
    attr   = emm_pkg::emm_attr_e'(d.map[d.addr[15:13]*`EMM_ATTR_W +: `EMM_ATTR_W]);
    onchip = d.addr >= `EMM_ONCHIP_BASE;
    d.to_emu = 1'b0;
    d.to_tgt = 1'b0;
    d.cause  = emm_pkg::BRK_NONE;
    // On-chip RAM and registers never leave the CPU
    if (d.valid && !onchip)
    begin
      unique case (attr)
        emm_pkg::ATTR_IROM, emm_pkg::ATTR_TURBO:
        begin
          d.to_emu = 1'b1;
          if (d.wr)
            d.cause = emm_pkg::BRK_WP;
        end
        emm_pkg::ATTR_ALT:
        begin
          d.to_emu = 1'b1;
          if (d.burst)
            d.cause = emm_pkg::BRK_TURBO;
        end
        emm_pkg::ATTR_ALT_WP:
        begin
          d.to_emu = 1'b1;
          if (d.wr)
            d.cause = emm_pkg::BRK_WP;
          else if (d.burst)
            d.cause = emm_pkg::BRK_TURBO;
        end
        emm_pkg::ATTR_USER:
        begin
          d.to_tgt = 1'b1;
          if (d.burst)
            d.cause = emm_pkg::BRK_TURBO;
        end
        default:
          d.cause = emm_pkg::BRK_NMAP;
      endcase
    end
  end
endmodule // emm_blk_decode
`default_nettype wire

/* emm_clk_sel.sv */
`timescale 1ns/1ps
`default_nettype none
module emm_clk_sel (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic sel_user,
  input  wire logic int_osc,
  input  wire logic user_oscillator_socket,
  output logic      cpu_clk
);
  typedef struct packed {
    logic [2:0] int_sy;
    logic [2:0] usr_sy;
    logic       int_lvl;
    logic       usr_lvl;
    logic       div;
    logic       out;
  } emm_clk_s;

  emm_clk_s st_r;
  emm_clk_s st_nxt;

  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.int_sy = {st_r.int_sy[1:0], int_osc};
    st_nxt.usr_sy = {st_r.usr_sy[1:0], user_oscillator_socket};
    if (st_r.int_sy[1] == st_r.int_sy[2])
      st_nxt.int_lvl = st_r.int_sy[2];
    if (st_r.usr_sy[1] == st_r.usr_sy[2])
      st_nxt.usr_lvl = st_r.usr_sy[2];
    if (st_nxt.usr_lvl && !st_r.usr_lvl)
      st_nxt.div = ~st_r.div;
    // Only two sources, none from the target
    st_nxt.out = sel_user ? st_r.div : st_r.int_lvl;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign cpu_clk = st_r.out;
endmodule // emm_clk_sel
`default_nettype wire

/* emm_map_break.sv */
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "emm_regs.svh"
module emm_map_break #(
  parameter int RST_CYC = `EMM_CPU_RST_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_valid,
  input  wire logic        cpu_write,
  input  wire logic        cpu_burst,
  output logic             cpu_sel_emu,
  output logic             cpu_sel_target,
  output logic             cpu_reset_b,
  output logic             cpu_halt,
  output logic             brk_pulse,
  output logic             setup_done,
  input  wire logic        int_osc,
  input  wire logic        user_oscillator_socket,
  output logic             cpu_clk
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    emm_pkg::emm_map_t map;
    logic              clk_user;
    logic              bmm;
    logic [2:0]        romsz;
    logic              setup;
    emm_pkg::emm_brk_e cause;
    logic              halted;
    logic              brk;
    logic [7:0]        rst_cnt;
    logic [15:0]       host_addr;
    logic              ack;
    logic [31:0]       rdata;
  } emm_top_s;

  emm_top_s st_r;
  emm_top_s st_nxt;

  emm_dec_if cpu_dec ();
  emm_dec_if host_dec ();

  logic wr_ok;
  logic rd_cyc;
  logic known;
  logic new_brk;
  logic brk_clr;

  // Each block keeps its old attribute if the new code is not allowed there
  function automatic emm_pkg::emm_map_t map_filter(input emm_pkg::emm_map_t old_m,
                                                   input emm_pkg::emm_map_t new_m);
    emm_pkg::emm_map_t res;
    logic [2:0]        a;
    res = old_m;
    for (int i = 0; i < `EMM_BLOCKS; i++)
    begin
      a = new_m[i*`EMM_ATTR_W +: `EMM_ATTR_W];
      // Top block takes user or unmapped only
      if (i == `EMM_BLOCKS - 1)
      begin
        if (a == emm_pkg::ATTR_USER || a == emm_pkg::ATTR_NONE)
          res[i*`EMM_ATTR_W +: `EMM_ATTR_W] = a;
      end
      // Six attributes in the lower blocks
      else if (a <= emm_pkg::ATTR_NONE)
        res[i*`EMM_ATTR_W +: `EMM_ATTR_W] = a;
    end
    return res;
  endfunction

  // Start-up map: ROM blocks from the bottom, user memory above
  function automatic emm_pkg::emm_map_t map_default(input logic [2:0] rom_blocks);
    emm_pkg::emm_map_t res;
    res = '0;
    for (int i = 0; i < `EMM_BLOCKS; i++)
      res[i*`EMM_ATTR_W +: `EMM_ATTR_W] = (i < rom_blocks) ? emm_pkg::ATTR_IROM : emm_pkg::ATTR_USER;
    return res;
  endfunction

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  assign cpu_dec.addr   = cpu_addr;
  assign cpu_dec.valid  = cpu_valid & cpu_reset_b & ~st_r.halted;
  assign cpu_dec.wr     = cpu_write;
  assign cpu_dec.burst  = cpu_burst;
  assign cpu_dec.map    = st_r.map;
  // Host accesses use the same live map
  assign host_dec.addr  = st_r.host_addr;
  assign host_dec.valid = 1'b1;
  assign host_dec.wr    = 1'b0;
  assign host_dec.burst = 1'b0;
  assign host_dec.map   = st_r.map;

  emm_blk_decode u_cpu_dec (
    .d (cpu_dec.dec)
  );

  emm_blk_decode u_host_dec (
    .d (host_dec.dec)
  );

  emm_clk_sel u_clk (
    .clock                  (clock),
    .rst_b                  (rst_b),
    .sel_user               (st_r.clk_user),
    .int_osc                (int_osc),
    .user_oscillator_socket (user_oscillator_socket),
    .cpu_clk                (cpu_clk)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  assign known   = paddr inside {`EMM_OFF_CTRL, `EMM_OFF_MAP, `EMM_OFF_ROMSZ,
                                 `EMM_OFF_STAT, `EMM_OFF_HADDR, `EMM_OFF_HRES};
  // Writes land at the edge where the master sees pready
  assign wr_ok   = psel & penable & pwrite & st_r.ack & known;
  assign rd_cyc  = psel & penable & ~st_r.ack;
  assign new_brk = cpu_dec.cause != emm_pkg::BRK_NONE;
  assign brk_clr = wr_ok && paddr == `EMM_OFF_CTRL && pwdata[`EMM_CTRL_BRKCLR];

  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.brk = 1'b0;
    st_nxt.ack = rd_cyc;
    if (st_r.rst_cnt != 8'h00)
      st_nxt.rst_cnt = st_r.rst_cnt - 8'h01;

    if (rd_cyc)
    begin
      st_nxt.rdata = 32'h0000_0000;
      unique case (paddr)
        `EMM_OFF_CTRL:  st_nxt.rdata = {30'h0, st_r.bmm, st_r.clk_user};
        `EMM_OFF_MAP:   st_nxt.rdata = {8'h00, st_r.map};
        `EMM_OFF_ROMSZ: st_nxt.rdata = {29'h0, st_r.romsz};
        `EMM_OFF_STAT:  st_nxt.rdata = {27'h0, ~cpu_reset_b, st_r.setup, st_r.halted, st_r.cause};
        `EMM_OFF_HADDR: st_nxt.rdata = {16'h0000, st_r.host_addr};
        `EMM_OFF_HRES:  st_nxt.rdata = {26'h0, host_dec.cause, 2'b00, host_dec.to_tgt, host_dec.to_emu};
        default:        st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    if (wr_ok)
    begin
      unique case (paddr)
        `EMM_OFF_CTRL:
        begin
          // Clock source change resets the CPU
          if (pwdata[`EMM_CTRL_CLK_USER] != st_r.clk_user)
            st_nxt.rst_cnt = 8'(RST_CYC);
          st_nxt.clk_user = pwdata[`EMM_CTRL_CLK_USER];
          st_nxt.bmm      = pwdata[`EMM_CTRL_BMM];
          // Entering burst manager mode unmaps everything off-chip
          if (pwdata[`EMM_CTRL_BMM] && !st_r.bmm)
          begin
            st_nxt.map     = `EMM_MAP_RST;
            st_nxt.rst_cnt = 8'(RST_CYC);
          end
          // Device reset restarts the CPU and clears the halt and break cause; the map is kept
          if (pwdata[`EMM_CTRL_DEVRST])
          begin
            st_nxt.rst_cnt = 8'(RST_CYC);
            st_nxt.halted  = 1'b0;
            st_nxt.cause   = emm_pkg::BRK_NONE;
          end
          if (pwdata[`EMM_CTRL_BRKCLR])
          begin
            st_nxt.halted = 1'b0;
            st_nxt.cause  = emm_pkg::BRK_NONE;
          end
          if (pwdata[`EMM_CTRL_SYSRST])
          begin
            st_nxt.map      = `EMM_MAP_RST;
            st_nxt.clk_user = 1'b0;
            st_nxt.bmm      = 1'b0;
            st_nxt.romsz    = 3'h0;
            st_nxt.setup    = 1'b0;
            st_nxt.halted   = 1'b0;
            st_nxt.cause    = emm_pkg::BRK_NONE;
            st_nxt.rst_cnt  = 8'(RST_CYC);
          end
        end
        `EMM_OFF_MAP:
        begin
          st_nxt.map = map_filter(st_r.map, pwdata[23:0]);
          if (st_nxt.map != st_r.map)
            st_nxt.rst_cnt = 8'(RST_CYC);
        end
        `EMM_OFF_ROMSZ:
        begin
          // Start-up ROM size sets the default ROM extent; in burst manager mode every block is unmapped instead
          st_nxt.romsz   = pwdata[2:0];
          st_nxt.map     = st_r.bmm ? `EMM_MAP_RST : map_default(pwdata[2:0]);
          st_nxt.setup   = 1'b1;
          st_nxt.rst_cnt = 8'(RST_CYC);
        end
        `EMM_OFF_HADDR: st_nxt.host_addr = pwdata[15:0];
        default:        st_nxt.host_addr = st_r.host_addr;
      endcase
    end

    // Break halts and latches; a new break beats a clear
    if (new_brk)
    begin
      st_nxt.halted = 1'b1;
      st_nxt.cause  = cpu_dec.cause;
      st_nxt.brk    = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r         <= '0;
      st_r.map     <= `EMM_MAP_RST;
      st_r.cause   <= emm_pkg::BRK_NONE;
      st_r.rst_cnt <= 8'(RST_CYC);
    end
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata         = st_r.rdata;
  assign pready         = st_r.ack;
  assign pslverr        = st_r.ack & ~known;
  assign cpu_reset_b    = st_r.setup & (st_r.rst_cnt == 8'h00);
  assign cpu_halt       = st_r.halted;
  assign brk_pulse      = st_r.brk;
  assign setup_done     = st_r.setup;
  assign cpu_sel_emu    = cpu_dec.to_emu & ~new_brk;
  assign cpu_sel_target = cpu_dec.to_tgt & ~new_brk;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_clk_chg_reset: assert property (
    $changed(st_r.clk_user) && !$past(wr_ok && pwdata[`EMM_CTRL_SYSRST])
    |-> !cpu_reset_b [*4])
    else $error("clock source change did not hold CPU reset");

  chk_map_chg_reset: assert property (
    $changed(st_r.map) |-> !cpu_reset_b)
    else $error("map change without CPU reset");

  chk_top_block: assert property (
    st_r.map[23:21] inside {emm_pkg::ATTR_USER, emm_pkg::ATTR_NONE})
    else $error("top block holds an illegal attribute");

  chk_nmap_break: assert property (
    cpu_dec.valid && cpu_addr < `EMM_ONCHIP_BASE
    && st_r.map[cpu_addr[15:13]*3 +: 3] == emm_pkg::ATTR_NONE
    |=> brk_pulse && cpu_halt && st_r.cause == emm_pkg::BRK_NMAP)
    else $error("unmapped access did not break");

  chk_wp_break: assert property (
    cpu_dec.valid && cpu_write && cpu_addr < `EMM_ONCHIP_BASE
    && st_r.map[cpu_addr[15:13]*3 +: 3] == emm_pkg::ATTR_IROM
    |=> st_r.cause == emm_pkg::BRK_WP ##1 cpu_halt)
    else $error("ROM write did not break");

  chk_user_route: assert property (
    cpu_dec.valid && !cpu_burst && cpu_addr < `EMM_ONCHIP_BASE
    && st_r.map[cpu_addr[15:13]*3 +: 3] == emm_pkg::ATTR_USER
    |-> cpu_sel_target && !cpu_sel_emu)
    else $error("user block not routed to target");

  chk_devrst_map: assert property (
    wr_ok && paddr == `EMM_OFF_CTRL && pwdata[4:0] == 5'h04
    |=> $stable(st_r.map) && !cpu_reset_b)
    else $error("device reset altered the map");

  chk_sysrst_setup: assert property (
    wr_ok && paddr == `EMM_OFF_CTRL && pwdata[`EMM_CTRL_SYSRST]
    |=> !setup_done && st_r.map == `EMM_MAP_RST && !cpu_reset_b)
    else $error("system reset did not restart setup");

  chk_bmm_unmap: assert property (
    $rose(st_r.bmm) |-> st_r.map == `EMM_MAP_RST)
    else $error("burst manager mode left blocks mapped");

  chk_halt_hold: assert property (
    cpu_halt && !wr_ok |=> cpu_halt)
    else $error("halt dropped without clear");

  chk_turbo_write: assert property (
    cpu_dec.valid && cpu_write && cpu_addr < `EMM_ONCHIP_BASE
    && st_r.map[cpu_addr[15:13]*3 +: 3] == emm_pkg::ATTR_TURBO
    |=> brk_pulse && st_r.cause == emm_pkg::BRK_WP)
    else $error("turbo block write did not break");

  chk_alt_burst: assert property (
    cpu_dec.valid && cpu_burst && cpu_addr < `EMM_ONCHIP_BASE
    && st_r.map[cpu_addr[15:13]*3 +: 3] == emm_pkg::ATTR_ALT
    |=> brk_pulse && st_r.cause == emm_pkg::BRK_TURBO)
    else $error("burst to alternate block did not break");

  chk_altwp_break: assert property (
    cpu_dec.valid && (cpu_write || cpu_burst) && cpu_addr < `EMM_ONCHIP_BASE
    && st_r.map[cpu_addr[15:13]*3 +: 3] == emm_pkg::ATTR_ALT_WP
    |=> brk_pulse && st_r.cause == ($past(cpu_write) ? emm_pkg::BRK_WP : emm_pkg::BRK_TURBO))
    else $error("protected alternate block access did not break");

  chk_user_burst: assert property (
    cpu_dec.valid && cpu_burst && cpu_addr < `EMM_ONCHIP_BASE
    && st_r.map[cpu_addr[15:13]*3 +: 3] == emm_pkg::ATTR_USER
    |=> brk_pulse && st_r.cause == emm_pkg::BRK_TURBO)
    else $error("burst to user block did not break");

  chk_romsz_map: assert property (
    wr_ok && paddr == `EMM_OFF_ROMSZ && !st_r.bmm && pwdata[2:0] != 3'h0
    |=> st_r.map[2:0] == emm_pkg::ATTR_IROM && st_r.map[23:21] == emm_pkg::ATTR_USER)
    else $error("ROM size did not set the default map");

  chk_host_route: assert property (
    st_r.host_addr < `EMM_ONCHIP_BASE
    && st_r.map[st_r.host_addr[15:13]*3 +: 3] == emm_pkg::ATTR_USER
    |-> host_dec.to_tgt && !host_dec.to_emu)
    else $error("host access to user block not routed to target");

  cov_turbo_brk: cover property (brk_pulse && st_r.cause == emm_pkg::BRK_TURBO);
  cov_host_tgt:  cover property (rd_cyc && paddr == `EMM_OFF_HRES && host_dec.to_tgt);
  cov_clk_user:  cover property ($rose(st_r.clk_user) ##[1:300] cpu_reset_b);
  cov_wp_brk:    cover property (brk_pulse && st_r.cause == emm_pkg::BRK_WP);
  cov_nmap_brk:  cover property (brk_pulse && st_r.cause == emm_pkg::BRK_NMAP);
endmodule // emm_map_break
`default_nettype wire

/* emm_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module emm_cpu_model (
  input  wire logic        clock,
  input  wire logic        sel_emu,
  input  wire logic        sel_target,
  input  wire logic        halt,
  input  wire logic        brk,
  output logic      [15:0] cpu_addr,
  output logic             cpu_valid,
  output logic             cpu_write,
  output logic             cpu_burst
);
  initial
  begin
    cpu_addr  = 16'hFFFF;
    cpu_valid = 1'b0;
    cpu_write = 1'b0;
    cpu_burst = 1'b0;
  end

  // ----------------------------------------
  // One bus cycle; route mid-cycle, break one edge later
  // ----------------------------------------
  task automatic access(input logic [15:0] a, input logic w, input logic b, output logic [3:0] res);
    @(posedge clock);
    cpu_addr  <= a;
    cpu_write <= w;
    cpu_burst <= b;
    cpu_valid <= 1'b1;
    @(negedge clock);
    res[1:0] = {sel_target, sel_emu};
    @(posedge clock);
    cpu_valid <= 1'b0;
    // Released lines must not keep the last value
    cpu_addr  <= ~a;
    cpu_write <= ~w;
    cpu_burst <= ~b;
    @(negedge clock);
    res[3:2] = {halt, brk};
  endtask
endmodule // emm_cpu_model
`default_nettype wire

/* tb_emm_map_break.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_emm_map_break;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        int_osc = 1'b0;
  logic        sock = 1'b0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, rerr, sel_emu, sel_tgt, cpu_reset_b, cpu_halt, brk_pulse, setup_done, cpu_clk;
  logic [15:0] cpu_addr;
  logic        cpu_valid, cpu_write, cpu_burst;
  logic [3:0]  res;
  logic [23:0] map_x;
  logic [23:0] tab [14];
  int          errors = 0;
  int          tests_run = 0;
  int          ccnt = 0;

  always #4 clock = ~clock;
  always #31.25 int_osc = ~int_osc;
  always #20.833 sock = ~sock;
  always @(posedge cpu_clk) ccnt++;

  emm_map_break #(.RST_CYC(4)) emm_map_break_i (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_addr(cpu_addr),
    .cpu_valid(cpu_valid), .cpu_write(cpu_write), .cpu_burst(cpu_burst), .cpu_sel_emu(sel_emu),
    .cpu_sel_target(sel_tgt), .cpu_reset_b(cpu_reset_b), .cpu_halt(cpu_halt), .brk_pulse(brk_pulse),
    .setup_done(setup_done), .int_osc(int_osc), .user_oscillator_socket(sock), .cpu_clk(cpu_clk)
  );

  emm_cpu_model emm_cpu_model_i (
    .clock(clock), .sel_emu(sel_emu), .sel_target(sel_tgt), .halt(cpu_halt), .brk(brk_pulse),
    .cpu_addr(cpu_addr), .cpu_valid(cpu_valid), .cpu_write(cpu_write), .cpu_burst(cpu_burst)
  );

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic test_done;
    if (errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; returns one edge after pready was seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clock);
      if (pready === 1'b1)
        break;
    end
    if (n == 50)
    begin
      errors++;
      test_done();
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never re-drives psel in this time step
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  // CPU reset must be asserted right after the write lands
  task automatic rst_seen;
    @(negedge clock);
    chk({31'h0, cpu_reset_b}, 32'h0);
    @(posedge clock);
  endtask

  task automatic wait_run;
    int n;
    for (n = 0; n < 300; n++)
    begin
      @(posedge clock);
      if (cpu_reset_b === 1'b1)
        break;
    end
    if (n == 300)
    begin
      errors++;
      test_done();
    end
  endtask

  task automatic count_clk(input int lo, input int hi);
    ccnt = 0;
    repeat (250) @(posedge clock);
    chk({31'h0, (ccnt >= lo && ccnt <= hi)}, 32'h1);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    // Fields: addr, write, burst, cause, {halt, brk, target, emu}
    tab = '{{16'h0000, 2'b00, 2'd0, 4'h1}, {16'h0000, 2'b10, 2'd1, 4'hC}, {16'h2000, 2'b01, 2'd0, 4'h1},
            {16'h2000, 2'b10, 2'd1, 4'hC}, {16'h4000, 2'b10, 2'd0, 4'h1}, {16'h4000, 2'b01, 2'd2, 4'hC},
            {16'h6000, 2'b00, 2'd0, 4'h1}, {16'h6000, 2'b10, 2'd1, 4'hC}, {16'h6000, 2'b01, 2'd2, 4'hC},
            {16'h8000, 2'b00, 2'd0, 4'h2}, {16'h8000, 2'b01, 2'd2, 4'hC}, {16'hA000, 2'b00, 2'd3, 4'hC},
            {16'hE000, 2'b00, 2'd0, 4'h2}, {16'hFA00, 2'b10, 2'd0, 4'h0}};
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rd(8'h04, 32'h00B6DB6D);
    rd(8'h0C, 32'h00000010);
    rd(8'h18, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, 8'h08, 32'h2);
    wait_run();
    map_x = 24'h0;
    for (int i = 2; i < 8; i++)
      map_x[3*i +: 3] = 3'h4;
    rd(8'h04, {8'h0, map_x});
    rd(8'h0C, 32'h00000008);
    // Blocks 0-5 take codes 0-5 in turn; block 7 is offered internal ROM, which it must refuse
    apb(1'b1, 8'h04, 32'h0012C688);
    rst_seen();
    wait_run();
    map_x = 24'h92C688;
    rd(8'h04, {8'h0, map_x});
    foreach (tab[i])
    begin
      emm_cpu_model_i.access(tab[i][23:8], tab[i][7], tab[i][6], res);
      chk({28'h0, res}, {28'h0, tab[i][3:0]});
      if (tab[i][3])
      begin
        @(posedge clock);
        rd(8'h0C, {28'h0, 4'hC} | {30'h0, tab[i][5:4]});
        apb(1'b1, 8'h00, 32'h10);
        wait_run();
      end
      else
        @(posedge clock);
    end
    apb(1'b1, 8'h10, 32'h8000);
    rd(8'h14, 32'h2);
    apb(1'b1, 8'h10, 32'h0000);
    rd(8'h14, 32'h1);
    apb(1'b1, 8'h10, 32'hA000);
    rd(8'h14, 32'h30);
    apb(1'b1, 8'h00, 32'h4);
    rst_seen();
    wait_run();
    rd(8'h04, {8'h0, map_x});
    count_clk(30, 34);
    apb(1'b1, 8'h00, 32'h1);
    rst_seen();
    wait_run();
    count_clk(22, 26);
    apb(1'b1, 8'h00, 32'h3);
    rd(8'h04, 32'h00B6DB6D);
    wait_run();
    emm_cpu_model_i.access(16'h8000, 1'b0, 1'b0, res);
    chk({28'h0, res}, 32'hC);
    @(posedge clock);
    rd(8'h0C, 32'h0000000F);
    apb(1'b1, 8'h00, 32'h9);
    rst_seen();
    chk({31'h0, setup_done}, 32'h0);
    test_done();
  end
endmodule // tb_emm_map_break
`default_nettype wire
